// ==== shared/link_event_regs.svh ====
`ifndef LINK_EVENT_REGS_SVH
`define LINK_EVENT_REGS_SVH

// Register offsets (byte addresses)
`define LINK_EVENT_STATUS_OFFSET 12'h044
`define LINK_EVENT_ENABLE_OFFSET 12'h048
// Summary register: two summary bits, write one to clear
`define LINK_SUMMARY_OFFSET 12'h040
`define LINK_ADDR_WIDTH 12

// Field positions
`define BIT_SUBACTION_GAP 0
`define BIT_ARB_RESET_GAP 1
`define BIT_CYCLE_COMPLETE 4
`define BIT_CYCLE_BEGIN 5
`define BIT_SECONDS_TICK 6
`define BIT_BUS_RESET 8
`define BIT_PHY_REG_RX 9
`define BIT_PHY_INT 10
`define BIT_CYC_ARB_FAIL 16
`define BIT_CYCLE_LOST 17
`define BIT_CYCLE_OVERRUN 18
`define BIT_ISO_ARB_FAIL 19
`define BIT_SELF_ID_ERROR 20
`define BIT_HEADER_ERROR 21
`define BIT_SUMMARY_LOW 0
`define BIT_SUMMARY_HIGH 1

// Implemented bits and summary groups
`define EVENT_IMPL_MASK 32'h003F0773
`define EVENT_HIGH_MASK 32'h003F0000
`define EVENT_LOW_MASK 32'h00000773

// Reset values
`define EVENT_STATUS_RESET 32'h00000000
`define EVENT_ENABLE_RESET 32'h00000000

`endif

// ==== shared/link_event_pkg.sv ====
`default_nettype none
package link_event_pkg;
    typedef logic [31:0] word_t;
    typedef logic [11:0] addr_t;
    typedef enum logic [1:0] {
        ACC_NONE,
        ACC_STATUS,
        ACC_ENABLE,
        ACC_SUMMARY
    } access_e;
endpackage
`default_nettype wire

// ==== rtl/event_flag_bit.sv ====
`timescale 1ns/10ps
`default_nettype none
// One sticky flag with set-over-clear priority
module event_flag_bit (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic set_i,
    input wire logic clear_i,
    output logic flag_o
);
    // Set wins against a simultaneous clear
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            flag_o <= 1'b0;
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (clear_i) begin
            flag_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/link_event_interrupt_block.sv ====
// Operation
// - Bus reset entry sets status bit 8
// - Seconds increment sets status bit 6
// - Cycle start sent/received sets bit 5
// - Subaction gap after cycle start sets 4
// - Arbitration reset gap sets bit 1
// - Any subaction gap sets bit 0
// - Flags sticky, write one clears
// - Reserved bits ignore writes, read zero
// - Enabled bits 21:16 set high summary
// - Enabled low group sets low summary
// - Disabled flags record but never interrupt
// - Summary set only on hardware set edge
// - Status and enables reset to zero
// - Header error bit 21, self-ID error 20
// - Cycle overrun sets 18, clears master
// - Two rollovers without received start set 17 if not master
// - Bits 19,16,10,9 from arbitration/PHY events
//
// The implementer's own choice: the strobed register port.
`include "link_event_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module link_event_interrupt_block
    import link_event_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Event sources, one-cycle pulses
    input wire logic phy_bus_reset_i,
    input wire logic seconds_inc_i,
    input wire logic cycle_start_tx_i,
    input wire logic cycle_start_rx_i,
    input wire logic subaction_gap_i,
    input wire logic arb_reset_gap_i,
    input wire logic header_error_i,
    input wire logic self_id_error_i,
    input wire logic iso_arb_fail_i,
    input wire logic cycle_too_long_i,
    input wire logic cycle_timer_rollover_i,
    input wire logic cyc_arb_fail_i,
    input wire logic phy_interrupt_i,
    input wire logic phy_reg_rx_i,
    // Cycle master control
    input wire logic cycle_master_set_i,
    input wire logic cycle_master_clr_i,
    output logic cycle_master_enable_o,
    // Summary and interrupt
    output logic link_summary_irq_low_o,
    output logic link_summary_irq_high_o,
    output logic irq_o
);
    // Register state
    wire word_t status;
    word_t link_event_enable;
    logic [1:0] summary;
    logic cycle_start_pending;
    logic [1:0] rollover_count;

    // Event gathering
    word_t set_vec;
    word_t clr_vec;
    logic cycle_start_seen;
    logic cycle_lost_set;
    logic rollover_armed;
    logic [1:0] summary_set;
    logic [1:0] summary_clr;

    // Per-event set strobes
    logic set_bus_reset;
    logic set_seconds_tick;
    logic set_cycle_begin;
    logic set_cycle_complete;
    logic set_arb_reset_gap;
    logic set_subaction_gap;
    logic set_header_error;
    logic set_self_id_error;
    logic set_cycle_overrun;
    logic set_iso_arb_fail;
    logic set_cyc_arb_fail;
    logic set_phy_int;
    logic set_phy_reg_rx;

    // Access decode
    access_e wr_sel;
    access_e rd_sel;
    logic wr_status;
    logic wr_enable;
    logic wr_summary;
    logic [31:0] summary_word;
    logic [31:0] next_rdata;

    // Next-state values
    word_t next_enable;
    logic next_cycle_start_pending;
    logic [1:0] next_rollover_count;
    logic next_cycle_master_enable;
    logic [1:0] next_summary;
    logic [31:0] next_rdata_out;

    // Decode an address into a register select
    // Offsets outside the map select nothing
    function automatic access_e decode(input addr_t a);
        case (a)
            `LINK_EVENT_STATUS_OFFSET: decode = ACC_STATUS;
            `LINK_EVENT_ENABLE_OFFSET: decode = ACC_ENABLE;
            `LINK_SUMMARY_OFFSET: decode = ACC_SUMMARY;
            default: decode = ACC_NONE;
        endcase
    endfunction

    // Keep only implemented event positions
    function automatic word_t impl_only(input word_t value);
        impl_only = value & `EVENT_IMPL_MASK;
    endfunction

    // Any enabled event of one group firing now
    function automatic logic group_hit(input word_t fired, input word_t armed, input word_t group);
        group_hit = |(fired & armed & group);
    endfunction

    // Register selects for this cycle's access
    assign wr_sel = wr_i ? decode(addr_i) : ACC_NONE;
    assign rd_sel = decode(addr_i);

    // One strobe per writable register
    assign wr_status = (wr_sel == ACC_STATUS);
    assign wr_enable = (wr_sel == ACC_ENABLE);
    assign wr_summary = (wr_sel == ACC_SUMMARY);

    // Either direction of cycle start counts
    assign cycle_start_seen = cycle_start_tx_i | cycle_start_rx_i;

    // Low group event strobes
    // Gap completes a cycle only after a start
    assign set_bus_reset = phy_bus_reset_i;
    assign set_seconds_tick = seconds_inc_i;
    assign set_cycle_begin = cycle_start_seen;
    assign set_cycle_complete = subaction_gap_i & cycle_start_pending;
    assign set_arb_reset_gap = arb_reset_gap_i;
    assign set_subaction_gap = subaction_gap_i;
    assign set_phy_int = phy_interrupt_i;
    assign set_phy_reg_rx = phy_reg_rx_i;

    // High group event strobes
    // Overrun also drops mastership below
    assign set_header_error = header_error_i;
    assign set_self_id_error = self_id_error_i;
    assign set_cycle_overrun = cycle_too_long_i;
    assign set_iso_arb_fail = iso_arb_fail_i;
    assign set_cyc_arb_fail = cyc_arb_fail_i;

    // Strobes gathered at their status positions
    // Unimplemented positions are masked off afterwards
    always_comb begin
        set_vec = 32'h00000000;
        set_vec[`BIT_BUS_RESET] = set_bus_reset;
        set_vec[`BIT_SECONDS_TICK] = set_seconds_tick;
        set_vec[`BIT_CYCLE_BEGIN] = set_cycle_begin;
        set_vec[`BIT_CYCLE_COMPLETE] = set_cycle_complete;
        set_vec[`BIT_ARB_RESET_GAP] = set_arb_reset_gap;
        set_vec[`BIT_SUBACTION_GAP] = set_subaction_gap;
        set_vec[`BIT_HEADER_ERROR] = set_header_error;
        set_vec[`BIT_SELF_ID_ERROR] = set_self_id_error;
        set_vec[`BIT_CYCLE_OVERRUN] = set_cycle_overrun;
        set_vec[`BIT_CYCLE_LOST] = cycle_lost_set;
        set_vec[`BIT_ISO_ARB_FAIL] = set_iso_arb_fail;
        set_vec[`BIT_CYC_ARB_FAIL] = set_cyc_arb_fail;
        set_vec[`BIT_PHY_INT] = set_phy_int;
        set_vec[`BIT_PHY_REG_RX] = set_phy_reg_rx;
        set_vec = impl_only(set_vec);
    end

    // Write-one-to-clear on implemented bits only
    // Writing zero leaves a flag as it is
    assign clr_vec = wr_status ? impl_only(wdata_i) : 32'h00000000;

    // Sticky flags, reserved positions stay zero
    // Each flag is its own cell so set beats clear per bit
    genvar g;
    generate
        for (g = 0; g < 32; g = g + 1) begin : gen_flag
            if (((`EVENT_IMPL_MASK >> g) & 1) != 0) begin : gen_impl
                event_flag_bit u_flag (
                    .sys_clk_i(sys_clk_i),
                    .nrst_i(nrst_i),
                    .set_i(set_vec[g]),
                    .clear_i(clr_vec[g]),
                    .flag_o(status[g])
                );
            end else begin : gen_rsvd
                assign status[g] = 1'b0;
            end
        end
    endgenerate

    // Enable value after a register write
    always_comb begin
        next_enable = link_event_enable;
        if (wr_enable) begin
            next_enable = impl_only(wdata_i);
        end
    end

    // Enable register
    // Reserved positions are never stored
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            link_event_enable <= `EVENT_ENABLE_RESET;
        end else begin
            link_event_enable <= next_enable;
        end
    end

    // Cycle start pending until the next subaction gap
    // A new start in the gap cycle keeps it pending
    always_comb begin
        next_cycle_start_pending = cycle_start_pending;
        if (cycle_start_seen) begin
            next_cycle_start_pending = 1'b1;
        end else if (subaction_gap_i) begin
            next_cycle_start_pending = 1'b0;
        end
    end

    // Pending flag register
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            cycle_start_pending <= 1'b0;
        end else begin
            cycle_start_pending <= next_cycle_start_pending;
        end
    end

    // One rollover already seen without a received start
    assign rollover_armed = (rollover_count == 2'd1);

    // Second rollover while not master and no start received
    assign cycle_lost_set = cycle_timer_rollover_i & ~cycle_master_enable_o
        & ~cycle_start_rx_i & rollover_armed;

    // Rollover count, restarted by a received start or by mastership
    always_comb begin
        next_rollover_count = rollover_count;
        if (cycle_start_rx_i || cycle_master_enable_o) begin
            next_rollover_count = 2'd0;
        end else if (cycle_timer_rollover_i) begin
            next_rollover_count = rollover_armed ? 2'd0 : 2'd1;
        end
    end

    // Rollover count register
    // Only the values zero and one are ever held
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            rollover_count <= 2'd0;
        end else begin
            rollover_count <= next_rollover_count;
        end
    end

    // Overrun and clear both win against a set
    // so an overrun always drops mastership
    always_comb begin
        next_cycle_master_enable = cycle_master_enable_o;
        if (cycle_too_long_i || cycle_master_clr_i) begin
            next_cycle_master_enable = 1'b0;
        end else if (cycle_master_set_i) begin
            next_cycle_master_enable = 1'b1;
        end
    end

    // Cycle master enable register
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            cycle_master_enable_o <= 1'b0;
        end else begin
            cycle_master_enable_o <= next_cycle_master_enable;
        end
    end

    // Summary set only by a fresh enabled hardware event
    // Enabling an already-set flag raises nothing
    assign summary_set[`BIT_SUMMARY_LOW] = group_hit(set_vec, link_event_enable, `EVENT_LOW_MASK);
    assign summary_set[`BIT_SUMMARY_HIGH] = group_hit(set_vec, link_event_enable, `EVENT_HIGH_MASK);
    assign summary_clr = wr_summary ? wdata_i[1:0] : 2'b00;

    // Summary bits, set wins over clear
    assign next_summary = summary_set | (summary & ~summary_clr);

    // Summary register
    // Cleared only by software, never by a flag clear
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            summary <= 2'b00;
        end else begin
            summary <= next_summary;
        end
    end

    // Summary bits out, one interrupt for both
    // Level output, held until software clears
    assign link_summary_irq_low_o = summary[`BIT_SUMMARY_LOW];
    assign link_summary_irq_high_o = summary[`BIT_SUMMARY_HIGH];
    assign irq_o = |summary;

    // Summary register read view
    assign summary_word = {30'h00000000, summary};

    // Read mux, unmapped reads return zero
    always_comb begin
        case (rd_sel)
            ACC_STATUS: next_rdata = status;
            ACC_ENABLE: next_rdata = link_event_enable;
            ACC_SUMMARY: next_rdata = summary_word;
            default: next_rdata = 32'h00000000;
        endcase
    end

    // Data launched at a read, zero otherwise
    always_comb begin
        next_rdata_out = 32'h00000000;
        if (rd_i) begin
            next_rdata_out = next_rdata;
        end
    end

    // Read data one cycle after the strobe
    // Zero outside the answer cycle
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            rdata_o <= 32'h00000000;
        end else begin
            rdata_o <= next_rdata_out;
        end
    end
endmodule
`default_nettype wire

// ==== tb/link_event_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module link_event_asserts (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic phy_bus_reset_i,
    input wire logic seconds_inc_i,
    input wire logic cycle_start_tx_i,
    input wire logic cycle_start_rx_i,
    input wire logic subaction_gap_i,
    input wire logic arb_reset_gap_i,
    input wire logic header_error_i,
    input wire logic self_id_error_i,
    input wire logic iso_arb_fail_i,
    input wire logic cycle_too_long_i,
    input wire logic cycle_timer_rollover_i,
    input wire logic cyc_arb_fail_i,
    input wire logic phy_interrupt_i,
    input wire logic phy_reg_rx_i,
    input wire logic cycle_master_enable_o,
    input wire logic link_summary_irq_low_o,
    input wire logic link_summary_irq_high_o
);
    // Event groups per summary bit, and a software clear of the low bit
    wire lo_ev = phy_bus_reset_i | seconds_inc_i | cycle_start_tx_i | cycle_start_rx_i | subaction_gap_i
        | arb_reset_gap_i | phy_interrupt_i | phy_reg_rx_i;
    wire hi_ev = header_error_i | self_id_error_i | iso_arb_fail_i | cycle_too_long_i | cycle_timer_rollover_i
        | cyc_arb_fail_i;
    wire clr_lo = wr_i && addr_i == 12'h040 && wdata_i[0];
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    property p_rsvd;
        rdata_o[31:22] == 10'h0 && rdata_o[15:11] == 5'h0 && !rdata_o[7] && rdata_o[3:2] == 2'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_rd_idle;
        !rd_i |=> rdata_o == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_reset;
        $rose(nrst_i) |-> !link_summary_irq_low_o && !link_summary_irq_high_o && !cycle_master_enable_o;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared");
    property p_overrun;
        cycle_too_long_i |=> !cycle_master_enable_o;
    endproperty
    a_overrun: assert property (p_overrun) else $error("master enable kept");
    property p_low_set;
        $rose(link_summary_irq_low_o) |-> $past(lo_ev);
    endproperty
    a_low_set: assert property (p_low_set) else $error("low summary without event");
    property p_high_set;
        $rose(link_summary_irq_high_o) |-> $past(hi_ev);
    endproperty
    a_high_set: assert property (p_high_set) else $error("high summary without event");
    property p_sticky;
        link_summary_irq_low_o && !clr_lo |=> link_summary_irq_low_o;
    endproperty
    a_sticky: assert property (p_sticky) else $error("low summary dropped");
    property p_clear;
        clr_lo && !lo_ev |=> !link_summary_irq_low_o;
    endproperty
    a_clear: assert property (p_clear) else $error("low summary not cleared");
endmodule
bind link_event_interrupt_block link_event_asserts u_chk (.*);
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import link_event_pkg::*;
    logic sys_clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, cycle_master_set_i = 0;
    logic cycle_master_enable_o, link_summary_irq_low_o, link_summary_irq_high_o, irq_o;
    addr_t addr_i = 12'h0;
    word_t wdata_i = 32'h0, rdata_o;
    logic [13:0] ev = 14'h0;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    word_t exp_tab [14] = '{32'h100, 32'h40, 32'h20, 32'h20, 32'h11, 32'h2, 32'h200000, 32'h100000,
        32'h80000, 32'h40000, 32'h0, 32'h10000, 32'h400, 32'h200};
    link_event_interrupt_block u_link_event_interrupt_block (.*, .phy_bus_reset_i(ev[0]), .seconds_inc_i(ev[1]),
        .cycle_start_tx_i(ev[2]), .cycle_start_rx_i(ev[3]), .subaction_gap_i(ev[4]), .arb_reset_gap_i(ev[5]),
        .header_error_i(ev[6]), .self_id_error_i(ev[7]), .iso_arb_fail_i(ev[8]), .cycle_too_long_i(ev[9]),
        .cycle_timer_rollover_i(ev[10]), .cyc_arb_fail_i(ev[11]), .phy_interrupt_i(ev[12]),
        .phy_reg_rx_i(ev[13]), .cycle_master_clr_i(1'b0));
    // Clock and hang guard
    always #10 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Register port cycles and event pulses
    task automatic wr(input addr_t a, input word_t d);
        @(posedge sys_clk_i) wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge sys_clk_i) wr_i <= 1'b0;
    endtask
    task automatic rd(input addr_t a, input word_t e);
        @(posedge sys_clk_i) rd_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i) rd_i <= 1'b0;
        #1 chk(rdata_o, e);
    endtask
    task automatic pulse(input int i);
        @(posedge sys_clk_i) ev[i] <= 1'b1;
        @(posedge sys_clk_i) ev <= 14'h0;
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        rd(12'h044, 32'h0);
        rd(12'h048, 32'h0);
        wr(12'h048, 32'hFFFFFFFF);
        rd(12'h048, 32'h003F0773);
        rd(12'h050, 32'h0);
        wr(12'h044, 32'hFFFFFFFF);
        rd(12'h044, 32'h0);
        @(posedge sys_clk_i) cycle_master_set_i <= 1'b1;
        @(posedge sys_clk_i) cycle_master_set_i <= 1'b0;
        #1 chk(cycle_master_enable_o, 1'b1);
        for (int i = 0; i < 14; i++) begin
            pulse(i);
            rd(12'h044, exp_tab[i]);
            chk(link_summary_irq_low_o, |(exp_tab[i] & 32'h773));
            chk(link_summary_irq_high_o, |(exp_tab[i] & 32'h3F0000));
            wr(12'h044, exp_tab[i]);
            wr(12'h040, 32'h3);
            rd(12'h044, 32'h0);
            chk(irq_o, 1'b0);
        end
        chk(cycle_master_enable_o, 1'b0);
        pulse(10);
        rd(12'h044, 32'h20000);
        chk(link_summary_irq_high_o, 1'b1);
        wr(12'h044, 32'h20000);
        wr(12'h040, 32'h3);
        wr(12'h048, 32'h0);
        pulse(0);
        rd(12'h044, 32'h100);
        chk(irq_o, 1'b0);
        wr(12'h048, 32'h100);
        rd(12'h048, 32'h100);
        chk(link_summary_irq_low_o, 1'b0);
        @(posedge sys_clk_i) ev[0] <= 1'b1;
        wr_i <= 1'b1;
        addr_i <= 12'h044;
        wdata_i <= 32'h100;
        @(posedge sys_clk_i) ev[0] <= 1'b0;
        wr_i <= 1'b0;
        rd(12'h044, 32'h100);
        chk(irq_o, 1'b1);
        wr(12'h044, 32'h0);
        rd(12'h044, 32'h100);
        close_out();
    end
endmodule
`default_nettype wire
